// *** hdl/slb_pkg.sv ***
// How it works
// - reset, host reset, mode change reload defaults
// - only host buffer writes change settings, except the device zeroing clear
// - CR/LF end code raises read request
// - word unit default, one selects bytes
// - unit also governs on-demand send length
// - send area defaults low 128 words
// - receive area defaults next 128 words
// - fixed length 127 units raises request
// - carrier check on, one disables it
// - clear request discards received data
// - full duplex default, half via registers
// - DTR/DSR default, DC codes via registers
// - device writes zero after clear
// - clear during send aborts, flags done
package slb_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int          ADDR_W = 12;
  localparam int          DATA_W = 16;
  localparam int          IDX_W  = 5;
  localparam logic [11:0] WIN_LO = 12'h100;
  localparam logic [11:0] WIN_HI = 12'h11f;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_RX_END_CODE   = 12'h100;
  localparam logic [11:0] OFF_LEN_UNIT      = 12'h103;
  localparam logic [11:0] OFF_TX_BASE       = 12'h104;
  localparam logic [11:0] OFF_TX_SIZE       = 12'h105;
  localparam logic [11:0] OFF_RX_BASE       = 12'h106;
  localparam logic [11:0] OFF_RX_SIZE       = 12'h107;
  localparam logic [11:0] OFF_RX_END_LEN    = 12'h108;
  localparam logic [11:0] OFF_CARRIER_CHECK = 12'h10b;
  localparam logic [11:0] OFF_RX_CLEAR      = 12'h10d;
  localparam logic [11:0] OFF_DUPLEX        = 12'h10f;
  localparam logic [11:0] OFF_SEND_PRIO     = 12'h110;
  localparam logic [11:0] OFF_RESUME        = 12'h111;
  localparam logic [11:0] OFF_FLOW_SEL      = 12'h11a;
  localparam logic [11:0] OFF_DC13          = 12'h11b;
  localparam logic [11:0] OFF_DC24          = 12'h11c;

  // ---------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------
  localparam logic [15:0] DEF_ZERO        = 16'h0000;
  localparam logic [15:0] DEF_RX_END_CODE = 16'h0d0a;
  localparam logic [15:0] DEF_TX_BASE     = 16'h0000;
  localparam logic [15:0] DEF_TX_SIZE     = 16'h0080;
  localparam logic [15:0] DEF_RX_BASE     = 16'h0080;
  localparam logic [15:0] DEF_RX_SIZE     = 16'h0080;
  localparam logic [15:0] DEF_RX_END_LEN  = 16'h007f;
  localparam logic [15:0] VAL_ONE         = 16'h0001;
  localparam logic [7:0]  CHAR_NONE       = 8'h00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ      = 10_000_000;
  localparam int LF_WAIT_MS  = 60;
  localparam int LF_WAIT_CYC = (CLK_HZ / 1000) * LF_WAIT_MS;

  typedef enum logic {CLR_IDLE, CLR_RUN} slb_clr_state_t;

  function automatic logic [15:0] slb_default(input logic [11:0] a);
    unique case (a)
      OFF_RX_END_CODE: slb_default = DEF_RX_END_CODE;
      OFF_TX_BASE:     slb_default = DEF_TX_BASE;
      OFF_TX_SIZE:     slb_default = DEF_TX_SIZE;
      OFF_RX_BASE:     slb_default = DEF_RX_BASE;
      OFF_RX_SIZE:     slb_default = DEF_RX_SIZE;
      OFF_RX_END_LEN:  slb_default = DEF_RX_END_LEN;
      default:         slb_default = DEF_ZERO;
    endcase
  endfunction : slb_default

endpackage : slb_pkg

// *** hdl/slb_timer.sv ***
`timescale 1ns/1ps
// one-shot down counter; expired pulses once when the count runs out
module slb_timer #(
  parameter int CYCLES = 600000,
  parameter int CNT_W  = 20
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic stop,
  output logic      running,
  output logic      expired
);

  localparam logic [CNT_W-1:0] LOAD = CNT_W'(CYCLES - 1);
  localparam logic [CNT_W-1:0] ZERO = '0;

  logic [CNT_W-1:0] cnt;

  always_ff @(posedge clk) begin
    if (rst || stop) begin
      cnt     <= ZERO;
      running <= 1'b0;
      expired <= 1'b0;
    end else if (start) begin
      cnt     <= LOAD;
      running <= 1'b1;
      expired <= 1'b0;
    end else if (running) begin
      expired <= (cnt == ZERO);
      running <= (cnt != ZERO);
      cnt     <= cnt - CNT_W'(1);
    end else begin
      expired <= 1'b0;
    end
  end

endmodule : slb_timer

// *** hdl/slb_config_bank.sv ***
`timescale 1ns/1ps
module slb_config_bank #(
  parameter int LF_WAIT_CYC = slb_pkg::LF_WAIT_CYC
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        HOST_RESET,
  input  wire logic        MODE_CHANGE,
  input  wire logic        BUFFER_WRITE_INSTRUCTION,
  input  wire logic        HOST_RD,
  input  wire logic [11:0] HOST_ADDR,
  input  wire logic [15:0] HOST_WDATA,
  input  wire logic        OTHER_WR,
  input  wire logic [11:0] OTHER_ADDR,
  input  wire logic        CFG_DONE,
  input  wire logic        RX_BYTE_VALID,
  input  wire logic [7:0]  RX_BYTE,
  input  wire logic        RX_READ_DONE,
  input  wire logic        SEND_REQ,
  input  wire logic        TX_BUSY,
  input  wire logic        TX_DONE,
  output logic [15:0]      HOST_RDATA,
  output logic             HOST_RVALID,
  output logic             OTHER_WR_REJECT,
  output logic             MODULE_READY_SIGNAL,
  output logic             RX_READ_REQ,
  output logic             RX_DISCARD,
  output logic             TX_ABORT,
  output logic             SEND_DONE_FLAG,
  output logic             BYTE_UNIT,
  output logic [15:0]      TX_AREA_BASE,
  output logic [15:0]      TX_AREA_SIZE,
  output logic [15:0]      RX_AREA_BASE,
  output logic [15:0]      RX_AREA_SIZE,
  output logic             CARRIER_CHECK_EN,
  output logic [15:0]      DUPLEX_MODE,
  output logic [15:0]      SIMUL_SEND_PRIORITY,
  output logic [15:0]      RESUME_SEND_METHOD,
  output logic [15:0]      FLOW_CONTROL_SELECT,
  output logic [15:0]      DC13_CODES,
  output logic [15:0]      DC24_CODES
);

  localparam int WORDS = int'(slb_pkg::WIN_HI - slb_pkg::WIN_LO) + 1;

  // ---------------------------------------------------------------
  // reset event synchronisers
  // ---------------------------------------------------------------
  logic [1:0] hrst_sync;
  logic [1:0] mode_sync;
  logic       reload;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      hrst_sync <= 2'h0;
      mode_sync <= 2'h0;
    end else begin
      hrst_sync <= {hrst_sync[0], HOST_RESET};
      mode_sync <= {mode_sync[0], MODE_CHANGE};
    end
  end

  // settings are not retained across any of these events
  assign reload = RST || hrst_sync[1] || mode_sync[1];

  // ---------------------------------------------------------------
  // settings window storage
  // ---------------------------------------------------------------
  logic [15:0]              cfg [WORDS];
  logic                     host_in_win;
  logic [slb_pkg::IDX_W-1:0] host_idx;
  logic                     clear_done;

  assign host_in_win = (HOST_ADDR >= slb_pkg::WIN_LO) &&
                       (HOST_ADDR <= slb_pkg::WIN_HI);
  assign host_idx    = slb_pkg::IDX_W'(HOST_ADDR - slb_pkg::WIN_LO);

  function automatic logic [slb_pkg::IDX_W-1:0] ix(input logic [11:0] a);
    ix = slb_pkg::IDX_W'(a - slb_pkg::WIN_LO);
  endfunction : ix

  always_ff @(posedge CLK_SYS) begin
    if (reload) begin
      for (int i = 0; i < WORDS; i++) begin
        cfg[i] <= slb_pkg::slb_default(12'(slb_pkg::WIN_LO + 12'(i)));
      end
    end else begin
      if (clear_done) begin
        cfg[ix(slb_pkg::OFF_RX_CLEAR)] <= slb_pkg::DEF_ZERO;
      end
      // host write after the ack so a fresh request is never lost
      if (BUFFER_WRITE_INSTRUCTION && host_in_win) begin
        cfg[host_idx] <= HOST_WDATA;
      end
    end
  end

  // any other path into the window is dropped and reported
  always_ff @(posedge CLK_SYS) begin
    if (reload) begin
      OTHER_WR_REJECT <= 1'b0;
    end else begin
      OTHER_WR_REJECT <= OTHER_WR && (OTHER_ADDR >= slb_pkg::WIN_LO) &&
                         (OTHER_ADDR <= slb_pkg::WIN_HI);
    end
  end

  // ---------------------------------------------------------------
  // host read port
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (reload) begin
      HOST_RDATA  <= slb_pkg::DEF_ZERO;
      HOST_RVALID <= 1'b0;
    end else begin
      HOST_RVALID <= HOST_RD;
      if (HOST_RD) begin
        HOST_RDATA <= host_in_win ? cfg[host_idx] : slb_pkg::DEF_ZERO;
      end
    end
  end

  // ---------------------------------------------------------------
  // start-up latch
  // ---------------------------------------------------------------
  logic ready_rise;

  assign ready_rise = CFG_DONE && !MODULE_READY_SIGNAL;

  always_ff @(posedge CLK_SYS) begin
    if (reload) begin
      MODULE_READY_SIGNAL <= 1'b0;
    end else if (CFG_DONE) begin
      MODULE_READY_SIGNAL <= 1'b1;
    end
  end

  // later writes to these latched settings still read back but no longer steer the link
  always_ff @(posedge CLK_SYS) begin
    if (reload) begin
      BYTE_UNIT           <= 1'b0;
      TX_AREA_BASE        <= slb_pkg::DEF_TX_BASE;
      TX_AREA_SIZE        <= slb_pkg::DEF_TX_SIZE;
      RX_AREA_BASE        <= slb_pkg::DEF_RX_BASE;
      RX_AREA_SIZE        <= slb_pkg::DEF_RX_SIZE;
      CARRIER_CHECK_EN    <= 1'b1;
      DUPLEX_MODE         <= slb_pkg::DEF_ZERO;
      SIMUL_SEND_PRIORITY <= slb_pkg::DEF_ZERO;
      RESUME_SEND_METHOD  <= slb_pkg::DEF_ZERO;
      FLOW_CONTROL_SELECT <= slb_pkg::DEF_ZERO;
      DC13_CODES          <= slb_pkg::DEF_ZERO;
      DC24_CODES          <= slb_pkg::DEF_ZERO;
    end else if (ready_rise) begin
      // unit also sizes on-demand sends downstream
      BYTE_UNIT <= cfg[ix(slb_pkg::OFF_LEN_UNIT)] ==
                   slb_pkg::VAL_ONE;
      TX_AREA_BASE        <= cfg[ix(slb_pkg::OFF_TX_BASE)];
      TX_AREA_SIZE        <= cfg[ix(slb_pkg::OFF_TX_SIZE)];
      RX_AREA_BASE        <= cfg[ix(slb_pkg::OFF_RX_BASE)];
      RX_AREA_SIZE        <= cfg[ix(slb_pkg::OFF_RX_SIZE)];
      CARRIER_CHECK_EN    <= cfg[ix(slb_pkg::OFF_CARRIER_CHECK)] !=
                             slb_pkg::VAL_ONE;
      DUPLEX_MODE         <= cfg[ix(slb_pkg::OFF_DUPLEX)];
      SIMUL_SEND_PRIORITY <= cfg[ix(slb_pkg::OFF_SEND_PRIO)];
      RESUME_SEND_METHOD  <= cfg[ix(slb_pkg::OFF_RESUME)];
      FLOW_CONTROL_SELECT <= cfg[ix(slb_pkg::OFF_FLOW_SEL)];
      DC13_CODES          <= cfg[ix(slb_pkg::OFF_DC13)];
      DC24_CODES          <= cfg[ix(slb_pkg::OFF_DC24)];
    end
  end

  // ---------------------------------------------------------------
  // receive clear sequence
  // ---------------------------------------------------------------
  slb_pkg::slb_clr_state_t clr_state;

  always_ff @(posedge CLK_SYS) begin
    if (reload) begin
      clr_state <= slb_pkg::CLR_IDLE;
    end else begin
      unique case (clr_state)
        slb_pkg::CLR_IDLE: begin
          if (cfg[ix(slb_pkg::OFF_RX_CLEAR)] == slb_pkg::VAL_ONE) begin
            clr_state <= slb_pkg::CLR_RUN;
          end
        end
        slb_pkg::CLR_RUN: begin
          clr_state <= slb_pkg::CLR_IDLE;
        end
      endcase
    end
  end

  assign clear_done = (clr_state == slb_pkg::CLR_RUN);

  always_ff @(posedge CLK_SYS) begin
    if (reload) begin
      RX_DISCARD <= 1'b0;
      TX_ABORT   <= 1'b0;
    end else begin
      RX_DISCARD <= clear_done;
      TX_ABORT   <= clear_done && TX_BUSY;
    end
  end

  // set wins over the host dropping its send request
  always_ff @(posedge CLK_SYS) begin
    if (reload) begin
      SEND_DONE_FLAG <= 1'b0;
    end else if (TX_DONE || (clear_done && TX_BUSY)) begin
      SEND_DONE_FLAG <= 1'b1;
    end else if (!SEND_REQ) begin
      SEND_DONE_FLAG <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // receive completion detection
  // ---------------------------------------------------------------
  logic [15:0] end_code;
  logic [15:0] end_len;
  logic        two_char;
  logic        got_first;
  logic        got_second;
  logic        lf_running;
  logic        lf_expired;
  logic        code_hit;
  logic        len_hit;
  logic [15:0] rx_count;
  logic        rx_half;
  logic        unit_tick;

  // completion code and length stay live: changeable mid-stream
  assign end_code   = cfg[ix(slb_pkg::OFF_RX_END_CODE)];
  assign end_len    = cfg[ix(slb_pkg::OFF_RX_END_LEN)];
  assign two_char   = end_code[15:8] != slb_pkg::CHAR_NONE;
  assign got_first  = RX_BYTE_VALID && two_char &&
                      (RX_BYTE == end_code[15:8]);
  assign got_second = RX_BYTE_VALID && (RX_BYTE == end_code[7:0]);

  slb_timer #(
    .CYCLES (LF_WAIT_CYC),
    .CNT_W  (32)
  ) u_lf_wait (
    .clk     (CLK_SYS),
    .rst     (reload),
    .start   (got_first),
    .stop    (got_second || clear_done),
    .running (lf_running),
    .expired (lf_expired)
  );

  // second char alone, first then second, or first timing out
  assign code_hit = got_second || lf_expired;
  assign unit_tick = RX_BYTE_VALID && (BYTE_UNIT || rx_half);
  assign len_hit   = unit_tick &&
                     (16'(rx_count + 16'h0001) >= end_len);

  always_ff @(posedge CLK_SYS) begin
    if (reload || clear_done) begin
      rx_count <= slb_pkg::DEF_ZERO;
      rx_half  <= 1'b0;
    end else if (code_hit || len_hit) begin
      rx_count <= slb_pkg::DEF_ZERO;
      rx_half  <= 1'b0;
    end else if (RX_BYTE_VALID) begin
      rx_half <= BYTE_UNIT ? 1'b0 : !rx_half;
      if (unit_tick) begin
        rx_count <= 16'(rx_count + 16'h0001);
      end
    end
  end

  // discard beats everything; new completion beats read-done
  always_ff @(posedge CLK_SYS) begin
    if (reload || clear_done) begin
      RX_READ_REQ <= 1'b0;
    end else if (code_hit || len_hit) begin
      RX_READ_REQ <= 1'b1;
    end else if (RX_READ_DONE) begin
      RX_READ_REQ <= 1'b0;
    end
  end

endmodule : slb_config_bank

// *** verif/slb_host.sv ***
`timescale 1ns/1ps
module slb_host (
  input  wire logic        clk,
  output logic             bwi,
  output logic             rd,
  output logic [11:0]      addr,
  output logic [15:0]      wdata,
  input  wire logic [15:0] rdata,
  input  wire logic        rvalid
);
  initial begin
    bwi   = 1'b0;
    rd    = 1'b0;
    addr  = 12'h000;
    wdata = 16'h0000;
  end

  // one-cycle buffer write strobe, the only path into the window
  task automatic put(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk) #1;
    bwi   = 1'b1;
    addr  = a;
    wdata = d;
    @(posedge clk) #1;
    bwi   = 1'b0;
    wdata = ~d;
  endtask : put

  // answer is due one edge after the strobe; no answer gives x
  task automatic get(input logic [11:0] a, output logic [15:0] d);
    @(posedge clk) #1;
    rd   = 1'b1;
    addr = a;
    @(posedge clk) #1;
    rd = 1'b0;
    d  = (rvalid === 1'b1) ? rdata : 16'hxxxx;
  endtask : get
endmodule : slb_host

// *** verif/slb_chk.sv ***
`timescale 1ns/1ps
module slb_chk #(
  parameter int LF_WAIT_CYC = 20
) (
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire logic        HOST_RESET,
  input wire logic        MODE_CHANGE,
  input wire logic        HOST_RD,
  input wire logic        OTHER_WR,
  input wire logic [11:0] OTHER_ADDR,
  input wire logic        CFG_DONE,
  input wire logic        TX_BUSY,
  input wire logic        HOST_RVALID,
  input wire logic        OTHER_WR_REJECT,
  input wire logic        MODULE_READY_SIGNAL,
  input wire logic        RX_READ_REQ,
  input wire logic        RX_DISCARD,
  input wire logic        TX_ABORT,
  input wire logic        SEND_DONE_FLAG,
  input wire logic        BYTE_UNIT,
  input wire logic [15:0] TX_AREA_BASE,
  input wire logic [15:0] TX_AREA_SIZE,
  input wire logic [15:0] RX_AREA_BASE,
  input wire logic        CARRIER_CHECK_EN
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  property p_rd_ans; HOST_RD |=> HOST_RVALID; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
  property p_rd_pulse; !HOST_RD |=> !HOST_RVALID; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("stray rvalid");
  property p_reject;
    OTHER_WR && OTHER_ADDR >= 12'h100 && OTHER_ADDR <= 12'h11f
      |=> OTHER_WR_REJECT;
  endproperty
  a_reject: assert property (p_reject) else $error("no reject");
  property p_reload;
    $fell(RST) |-> !MODULE_READY_SIGNAL && !BYTE_UNIT && CARRIER_CHECK_EN
      && TX_AREA_BASE == 16'h0000 && TX_AREA_SIZE == 16'h0080
      && RX_AREA_BASE == 16'h0080;
  endproperty
  a_reload: assert property (p_reload) else $error("bad default");
  // synchronised resets act two edges late, so look back two
  property p_ready;
    CFG_DONE && !MODULE_READY_SIGNAL && !$past(HOST_RESET)
      && !$past(HOST_RESET, 2) && !$past(MODE_CHANGE)
      && !$past(MODE_CHANGE, 2) |=> MODULE_READY_SIGNAL;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_latched;
    MODULE_READY_SIGNAL && $past(MODULE_READY_SIGNAL)
      |-> $stable(BYTE_UNIT) && $stable(TX_AREA_BASE);
  endproperty
  a_latched: assert property (p_latched) else $error("setting moved");
  property p_word; !MODULE_READY_SIGNAL |-> !BYTE_UNIT; endproperty
  a_word: assert property (p_word) else $error("byte unit early");
  property p_clr_wins; RX_DISCARD |-> !RX_READ_REQ; endproperty
  a_clr_wins: assert property (p_clr_wins) else $error("req kept");
  property p_clr_once; RX_DISCARD |=> !RX_DISCARD; endproperty
  a_clr_once: assert property (p_clr_once) else $error("clear repeats");
  property p_abort;
    TX_ABORT |-> SEND_DONE_FLAG && RX_DISCARD && $past(TX_BUSY);
  endproperty
  a_abort: assert property (p_abort) else $error("bad abort");

  c_abort: cover property (TX_ABORT);
  c_req: cover property ($rose(RX_READ_REQ));
  c_ready: cover property ($rose(MODULE_READY_SIGNAL));
endmodule : slb_chk

bind slb_config_bank slb_chk #(.LF_WAIT_CYC(LF_WAIT_CYC)) u_chk (
  .CLK_SYS(CLK_SYS), .RST(RST), .HOST_RESET(HOST_RESET),
  .MODE_CHANGE(MODE_CHANGE), .HOST_RD(HOST_RD), .OTHER_WR(OTHER_WR),
  .OTHER_ADDR(OTHER_ADDR), .CFG_DONE(CFG_DONE), .TX_BUSY(TX_BUSY),
  .HOST_RVALID(HOST_RVALID), .OTHER_WR_REJECT(OTHER_WR_REJECT),
  .MODULE_READY_SIGNAL(MODULE_READY_SIGNAL), .RX_READ_REQ(RX_READ_REQ),
  .RX_DISCARD(RX_DISCARD), .TX_ABORT(TX_ABORT),
  .SEND_DONE_FLAG(SEND_DONE_FLAG), .BYTE_UNIT(BYTE_UNIT),
  .TX_AREA_BASE(TX_AREA_BASE), .TX_AREA_SIZE(TX_AREA_SIZE),
  .RX_AREA_BASE(RX_AREA_BASE), .CARRIER_CHECK_EN(CARRIER_CHECK_EN));

// *** verif/slb_config_bank_tb.sv ***
`timescale 1ns/1ps
module slb_config_bank_tb;
  logic        clk = 1'b0, rst = 1'b1, hrst = 1'b0, mchg = 1'b0;
  logic        owr = 1'b0, cfg = 1'b0, rxv = 1'b0, rdone = 1'b0;
  logic        sreq = 1'b0, busy = 1'b0, tdone = 1'b0;
  logic [11:0] oaddr = 12'h000;
  logic [7:0]  rxb = 8'h00;
  logic        bwi, hrd, rvalid, rej, rdy, req, disc, abrt, sdone, bu, cd;
  logic [11:0] haddr;
  logic [15:0] wd, rdat, v, tb_, ts, rb, rs, dup, pri, res, flo, d13, d24;
  logic [11:0] offs [9] = '{12'h100, 12'h103, 12'h104, 12'h105, 12'h106,
                             12'h107, 12'h108, 12'h10b, 12'h10d};
  logic [15:0] defs [9] = '{16'h0d0a, 16'h0000, 16'h0000, 16'h0080,
                             16'h0080, 16'h0080, 16'h007f, 16'h0000, 16'h0000};
  int          failures = 0, check_count = 0;

  initial forever #50 clk = ~clk;

  slb_config_bank #(.LF_WAIT_CYC(20)) uut (
    .CLK_SYS(clk), .RST(rst), .HOST_RESET(hrst), .MODE_CHANGE(mchg),
    .BUFFER_WRITE_INSTRUCTION(bwi), .HOST_RD(hrd), .HOST_ADDR(haddr),
    .HOST_WDATA(wd), .OTHER_WR(owr), .OTHER_ADDR(oaddr), .CFG_DONE(cfg),
    .RX_BYTE_VALID(rxv), .RX_BYTE(rxb), .RX_READ_DONE(rdone),
    .SEND_REQ(sreq), .TX_BUSY(busy), .TX_DONE(tdone), .HOST_RDATA(rdat),
    .HOST_RVALID(rvalid), .OTHER_WR_REJECT(rej), .MODULE_READY_SIGNAL(rdy),
    .RX_READ_REQ(req), .RX_DISCARD(disc), .TX_ABORT(abrt),
    .SEND_DONE_FLAG(sdone), .BYTE_UNIT(bu), .TX_AREA_BASE(tb_),
    .TX_AREA_SIZE(ts), .RX_AREA_BASE(rb), .RX_AREA_SIZE(rs),
    .CARRIER_CHECK_EN(cd), .DUPLEX_MODE(dup), .SIMUL_SEND_PRIORITY(pri),
    .RESUME_SEND_METHOD(res), .FLOW_CONTROL_SELECT(flo), .DC13_CODES(d13),
    .DC24_CODES(d24));

  slb_host host (.clk(clk), .bwi(bwi), .rd(hrd), .addr(haddr), .wdata(wd),
                 .rdata(rdat), .rvalid(rvalid));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic chk(input string what, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic rdc(input logic [11:0] a, input logic [15:0] e);
    host.get(a, v);
    chk($sformatf("word %h", a), e, v);
  endtask : rdc
  task automatic rx(input logic [7:0] b);
    rxb = b;
    rxv = 1'b1;
    cyc(1);
    rxv = 1'b0;
    cyc(1);
  endtask : rx
  task automatic pulse_cfg();
    cfg = 1'b1;
    cyc(1);
    cfg = 1'b0;
  endtask : pulse_cfg
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    int i;
    cyc(3);
    rst = 1'b0;
    for (i = 0; i < 9; i++) rdc(offs[i], defs[i]);
    rdc(12'h200, 16'h0000);
    chk("rx size", 16'h0080, rs);
    chk("carrier", 16'h0001, {15'h0, cd});
    oaddr = 12'h108;
    owr = 1'b1;
    cyc(1);
    owr = 1'b0;
    chk("reject", 16'h0001, {15'h0, rej});
    rdc(12'h108, 16'h007f);
    host.put(12'h103, 16'h0001);
    host.put(12'h104, 16'h0120);
    host.put(12'h105, 16'h0040);
    host.put(12'h106, 16'h0200);
    host.put(12'h107, 16'h0100);
    host.put(12'h10b, 16'h0001);
    host.put(12'h10f, 16'h0001);
    host.put(12'h110, 16'h0001);
    host.put(12'h111, 16'h0001);
    host.put(12'h11a, 16'h0001);
    host.put(12'h11b, 16'h1113);
    host.put(12'h11c, 16'h1214);
    chk("unit", 16'h0000, {15'h0, bu});
    pulse_cfg();
    chk("ready", 16'h0001, {15'h0, rdy});
    chk("unit", 16'h0001, {15'h0, bu});
    chk("tx base", 16'h0120, tb_);
    chk("tx size", 16'h0040, ts);
    chk("rx base", 16'h0200, rb);
    chk("rx size", 16'h0100, rs);
    chk("carrier", 16'h0000, {15'h0, cd});
    chk("duplex", 16'h0001, dup);
    chk("flow", 16'h0001, flo);
    chk("dc13", 16'h1113, d13);
    chk("prio", 16'h0001, pri);
    chk("resume", 16'h0001, res);
    chk("dc24", 16'h1214, d24);
    host.put(12'h104, 16'h0200);
    chk("tx base", 16'h0120, tb_);
    rdc(12'h104, 16'h0200);
    host.put(12'h100, 16'h0000);
    host.put(12'h108, 16'h0003);
    rx(8'h41);
    rx(8'h42);
    chk("req", 16'h0000, {15'h0, req});
    rx(8'h43);
    chk("req", 16'h0001, {15'h0, req});
    rdone = 1'b1;
    cyc(1);
    rdone = 1'b0;
    host.put(12'h108, 16'h007f);
    host.put(12'h100, 16'h0d0a);
    rx(8'h0d);
    chk("req", 16'h0000, {15'h0, req});
    rx(8'h0a);
    chk("req", 16'h0001, {15'h0, req});
    rdone = 1'b1;
    cyc(1);
    rdone = 1'b0;
    rx(8'h0d);
    cyc(5);
    chk("req", 16'h0000, {15'h0, req});
    cyc(20);
    chk("req", 16'h0001, {15'h0, req});
    sreq = 1'b1;
    busy = 1'b1;
    host.put(12'h10d, 16'h0001);
    for (i = 0; i < 8 && disc !== 1'b1; i++) cyc(1);
    chk("discard", 16'h0001, {15'h0, disc});
    chk("abort", 16'h0001, {15'h0, abrt});
    chk("done", 16'h0001, {15'h0, sdone});
    chk("req", 16'h0000, {15'h0, req});
    busy = 1'b0;
    sreq = 1'b0;
    rdc(12'h10d, 16'h0000);
    chk("done", 16'h0000, {15'h0, sdone});
    tdone = 1'b1;
    cyc(1);
    tdone = 1'b0;
    chk("done", 16'h0001, {15'h0, sdone});
    cyc(1);
    chk("done", 16'h0000, {15'h0, sdone});
    hrst = 1'b1;
    cyc(4);
    hrst = 1'b0;
    cyc(4);
    chk("ready", 16'h0000, {15'h0, rdy});
    chk("tx base", 16'h0000, tb_);
    rdc(12'h104, 16'h0000);
    host.put(12'h100, 16'h0000);
    host.put(12'h108, 16'h0002);
    pulse_cfg();
    chk("unit", 16'h0000, {15'h0, bu});
    for (i = 0; i < 3; i++) rx(8'h30);
    chk("req", 16'h0000, {15'h0, req});
    rx(8'h31);
    chk("req", 16'h0001, {15'h0, req});
    mchg = 1'b1;
    cyc(4);
    mchg = 1'b0;
    cyc(4);
    chk("req", 16'h0000, {15'h0, req});
    rdc(12'h108, 16'h007f);
    close_out();
  end

  // whole run is well under two thousand cycles
  initial begin
    cyc(20000);
    failures++;
    close_out();
  end
endmodule : slb_config_bank_tb
